// ==== hdl/bdu_core.sv ====
// Single-wire background debug unit: command engine, modes, security, low power
// Overview of operation
// - Host talks to the unit through one two-way pin and nothing else.
// - Pin level at reset, with the emulation mode input, picks the operating mode; afterwards it is the debug line.
// - Long host low gets a sync pulse back; completed operations answer with an ack pulse.
// - The tagged-go command is not implemented and is ignored.
// - Family identification byte reads from a fixed debug-space address.
// - Nine hardware commands work without active state and use only free bus cycles.
// - Firmware commands dispatch through a lookup table in firmware ROM.
// - Firmware commands run only after the unit has been enabled.
// - Special single-chip mode leaves reset enabled and active.
// - Emulation modes leave reset enabled but not active.
// - Emulation modes set the clock source select bit out of reset unless the device is secured.
// - Secured device allows a small subset and blocks non-volatile memory access.
// - Secured special single-chip with failed erase check still reaches register space.
// - Hardware commands work until every bus master is in stop.
// - CPU wait or stop ignores firmware and background; reads, writes and ack enable/disable remain.
// - CPU cannot enter low power while the unit is active.
// - Unit clocks stop with all masters stopped and restart when any leaves.
// - Clock restart soft-resets: clears instruction, aborts command, disables ack.
// - The unit has no run-mode power saving controls.
// - Hardware sets the active flag; only the firmware table exit clears it.
// - After the reset strap, clock source select is written only by the hardware register write command.
`default_nettype none
module bdu_core #(
	parameter logic [7:0] FAMILY_ID = 8'h5a // Arbitrary value
) (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        pin_i,
	output logic             pin_o,
	output logic             pin_oen_o,
	input  wire logic        emul_mode_i,
	input  wire logic        secure_i,
	input  wire logic        nvm_erased_i,
	input  wire logic        all_stop_i,
	input  wire logic        cpu_lowpower_i,
	input  wire logic        bus_free_i,
	input  wire logic        bus_ack_i,
	input  wire logic [15:0] bus_rdata_i,
	output logic             bus_req_o,
	output logic             bus_we_o,
	output logic             bus_word_o,
	output logic [23:0]      bus_addr_o,
	output logic [15:0]      bus_wdata_o,
	output logic             fw_cmd_valid_o,
	output logic [7:0]       fw_cmd_o,
	output logic [23:0]      fw_entry_addr_o,
	input  wire logic        fw_done_i,
	input  wire logic        fw_exit_i,
	output logic             bgnd_req_o,
	output logic             lowpower_block_o,
	output logic             clk_stop_o,
	output logic             special_mode_o,
	output logic             debug_enable_o,
	output logic             clksel_o
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		bdu_pkg::bdu_state_t st;
		logic [7:0]          cmd;
		logic [23:0]         addr;
		logic [15:0]         data;
		logic [4:0]          cnt;
		logic                enable;
		logic                active;
		logic                clksel;
		logic                ack_en;
		logic                special;
		logic                emul;
		logic                strap_done;
		logic                stop_q;
		logic                fw_pulse;
	} bdu_core_t;
	bdu_core_t q, next_q;

	logic       rx_fall;
	logic       rx_bit_valid;
	logic       rx_bit;
	logic       rx_sync;
	logic       tx_start;
	logic [7:0] tx_delay;
	logic [7:0] tx_len;
	logic       tx_busy;
	logic [7:0] cmd_w;
	logic       secure_eff;
	logic       is_bd;
	logic       is_wr;
	logic       is_rd;
	logic       is_word;
	logic       is_fw;
	logic       access_ok;
	logic       in_case;
	logic [7:0] bd_rdata;
	logic [7:0] fw_index;

	// ****************************************
	// Pin engines
	// ****************************************
	bdu_pin_rx u_rx (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.pin_i       (pin_i),
		.mute_i      (tx_busy),
		.fall_o      (rx_fall),
		.bit_valid_o (rx_bit_valid),
		.bit_o       (rx_bit),
		.sync_o      (rx_sync)
	);
	bdu_pin_tx u_tx (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.start_i (tx_start),
		.delay_i (tx_delay),
		.len_i   (tx_len),
		.oen_o   (pin_oen_o),
		.busy_o  (tx_busy)
	);
	assign pin_o = 1'b0;

	// ****************************************
	// Decode
	// ****************************************
	assign cmd_w = {q.cmd[6:0], rx_bit};
	assign secure_eff = secure_i & ~nvm_erased_i;
	assign is_bd = (q.cmd == bdu_pkg::CMD_READ_DEBUG_REG_COMMAND) || (q.cmd == bdu_pkg::CMD_WRITE_DEBUG_REG_COMMAND);
	assign is_wr = (q.cmd == bdu_pkg::CMD_WRITE_DEBUG_REG_COMMAND) || (q.cmd == bdu_pkg::CMD_WRITE_BYTE)
		|| (q.cmd == bdu_pkg::CMD_WRITE_WORD);
	assign is_rd = (q.cmd == bdu_pkg::CMD_READ_DEBUG_REG_COMMAND) || (q.cmd == bdu_pkg::CMD_READ_BYTE)
		|| (q.cmd == bdu_pkg::CMD_READ_WORD);
	assign is_word = (q.cmd == bdu_pkg::CMD_READ_WORD) || (q.cmd == bdu_pkg::CMD_WRITE_WORD);
	assign is_fw = (cmd_w >= bdu_pkg::FW_CMD_BASE) && (cmd_w < bdu_pkg::FW_CMD_BASE + bdu_pkg::FW_CMD_COUNT);
	// Secured parts see nothing but register space, and that only in special mode
	assign access_ok = !secure_eff || (q.special && q.addr < bdu_pkg::REG_SPACE_TOP);
	assign in_case = q.strap_done && !all_stop_i && !q.stop_q && !rx_sync;

	always_comb begin
		bd_rdata = 8'h00;
		if (q.addr[7:0] == bdu_pkg::OFS_STATUS) begin
			bd_rdata[bdu_pkg::ST_ENABLE_BIT] = q.enable;
			bd_rdata[bdu_pkg::ST_ACTIVE_BIT] = q.active;
			bd_rdata[bdu_pkg::ST_CLKSEL_BIT] = q.clksel;
			bd_rdata[bdu_pkg::ST_UNSEC_BIT] = q.special & secure_i & nvm_erased_i;
		end else if (q.addr[7:0] == bdu_pkg::OFS_FAMILY) begin
			bd_rdata = FAMILY_ID;
		end
	end

	// ****************************************
	// Command engine
	// ****************************************
	always_comb begin
		next_q = q;
		next_q.stop_q = all_stop_i;
		next_q.fw_pulse = 1'b0;
		tx_start = 1'b0;
		tx_delay = 8'h00;
		tx_len = 8'h00;
		if (!q.strap_done) begin
			// Pin still holds its strap level in the first cycle after release
			next_q.strap_done = 1'b1;
			next_q.special = ~pin_i;
			next_q.emul = emul_mode_i & pin_i;
			next_q.enable = ~pin_i | (emul_mode_i & pin_i);
			next_q.active = ~pin_i;
			next_q.clksel = emul_mode_i & pin_i & ~secure_i;
		end else if (all_stop_i) begin
			// Clocks are gated off here; nothing is taken
			next_q.st = bdu_pkg::ST_CMD;
			next_q.cnt = 5'h00;
		end else if (q.stop_q) begin
			next_q.st = bdu_pkg::ST_CMD;
			next_q.cmd = 8'h00;
			next_q.cnt = 5'h00;
			next_q.ack_en = 1'b0;
		end else if (rx_sync) begin
			// A sync aborts whatever was under way
			next_q.st = bdu_pkg::ST_CMD;
			next_q.cnt = 5'h00;
			tx_start = !tx_busy;
			tx_delay = bdu_pkg::SYNC_GAP_CYC;
			tx_len = bdu_pkg::SYNC_PULSE_CYC;
		end else begin
			if (fw_exit_i) begin
				next_q.active = 1'b0;
			end
			unique case (q.st)
				bdu_pkg::ST_CMD: begin
					if (rx_bit_valid) begin
						next_q.cmd = cmd_w;
						next_q.cnt = q.cnt + 5'h01;
						if (q.cnt == bdu_pkg::BYTE_LAST) begin
							next_q.cnt = 5'h00;
							if (cmd_w == bdu_pkg::CMD_BACKGROUND) begin
								if (q.enable && !cpu_lowpower_i) begin
									next_q.active = 1'b1;
									next_q.st = bdu_pkg::ST_ACK;
								end
							end else if (cmd_w == bdu_pkg::CMD_ACK_ENABLE) begin
								next_q.ack_en = 1'b1;
								next_q.st = bdu_pkg::ST_ACK;
							end else if (cmd_w == bdu_pkg::CMD_ACK_DISABLE) begin
								next_q.ack_en = 1'b0;
							end else if (cmd_w == bdu_pkg::CMD_READ_DEBUG_REG_COMMAND || cmd_w == bdu_pkg::CMD_WRITE_DEBUG_REG_COMMAND
								|| cmd_w == bdu_pkg::CMD_READ_BYTE || cmd_w == bdu_pkg::CMD_WRITE_BYTE
								|| cmd_w == bdu_pkg::CMD_READ_WORD || cmd_w == bdu_pkg::CMD_WRITE_WORD) begin
								next_q.st = bdu_pkg::ST_ADDR;
							end else if (is_fw && q.enable && q.active && !cpu_lowpower_i && !secure_eff) begin
								next_q.st = bdu_pkg::ST_FW;
								next_q.fw_pulse = 1'b1;
							end
							// Tagged go and unknown opcodes fall back to waiting
						end
					end
				end
				bdu_pkg::ST_ADDR: begin
					if (rx_bit_valid) begin
						next_q.addr = {q.addr[22:0], rx_bit};
						next_q.cnt = q.cnt + 5'h01;
						if (q.cnt == bdu_pkg::ADDR_LAST) begin
							next_q.cnt = 5'h00;
							next_q.st = is_wr ? bdu_pkg::ST_WDATA : bdu_pkg::ST_ACCESS;
						end
					end
				end
				bdu_pkg::ST_WDATA: begin
					if (rx_bit_valid) begin
						next_q.data = {q.data[14:0], rx_bit};
						next_q.cnt = q.cnt + 5'h01;
						if (q.cnt == (is_word ? bdu_pkg::WORD_LAST : bdu_pkg::BYTE_LAST)) begin
							next_q.cnt = 5'h00;
							next_q.st = bdu_pkg::ST_ACCESS;
						end
					end
				end
				bdu_pkg::ST_ACCESS: begin
					if (is_bd) begin
						next_q.st = bdu_pkg::ST_ACK;
						if (!is_wr) begin
							next_q.data = {bd_rdata, 8'h00};
						end else if (!secure_eff && q.addr[7:0] == bdu_pkg::OFS_STATUS) begin
							next_q.enable = q.data[bdu_pkg::ST_ENABLE_BIT];
							next_q.clksel = q.data[bdu_pkg::ST_CLKSEL_BIT];
						end
					end else if (!access_ok) begin
						next_q.data = 16'h0000;
						next_q.st = bdu_pkg::ST_ACK;
					end else if (bus_req_o && bus_ack_i) begin
						if (!is_wr) begin
							next_q.data = is_word ? bus_rdata_i : {bus_rdata_i[7:0], 8'h00};
						end
						next_q.st = bdu_pkg::ST_ACK;
					end
				end
				bdu_pkg::ST_FW: begin
					if (fw_done_i) begin
						next_q.st = bdu_pkg::ST_ACK;
					end
				end
				bdu_pkg::ST_ACK: begin
					if (!q.ack_en || !tx_busy) begin
						tx_start = q.ack_en;
						tx_len = bdu_pkg::ACK_CYC;
						next_q.st = is_rd ? bdu_pkg::ST_TX : bdu_pkg::ST_CMD;
						next_q.cnt = is_word ? bdu_pkg::WORD_LAST : bdu_pkg::BYTE_LAST;
						if (!is_rd) begin
							next_q.cnt = 5'h00;
						end
					end
				end
				bdu_pkg::ST_TX: begin
					if (rx_fall) begin
						// Host opens each cell; a zero is held low past its sample point
						tx_start = ~q.data[15];
						tx_len = bdu_pkg::TX_LOW_CYC;
						next_q.data = {q.data[14:0], 1'b0};
					end
					// Cells are counted by their decoded bit so the last one never leaks into the next command
					if (rx_bit_valid) begin
						next_q.cnt = q.cnt - 5'h01;
						if (q.cnt == 5'h00) begin
							next_q.cnt = 5'h00;
							next_q.st = bdu_pkg::ST_CMD;
						end
					end
				end
				default: begin
					next_q.st = bdu_pkg::ST_CMD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus_req_o = (q.st == bdu_pkg::ST_ACCESS) && !is_bd && access_ok && bus_free_i;
	assign bus_we_o = is_wr;
	assign bus_word_o = is_word;
	assign bus_addr_o = q.addr;
	assign bus_wdata_o = q.data;
	assign fw_index = q.cmd - bdu_pkg::FW_CMD_BASE;
	assign fw_entry_addr_o = bdu_pkg::FW_TABLE_BASE + {15'h0000, fw_index, 1'b0};
	assign fw_cmd_valid_o = q.fw_pulse;
	assign fw_cmd_o = q.cmd;
	assign bgnd_req_o = q.active;
	assign lowpower_block_o = q.active;
	// Stopping the unit clocks is left to the clock controller; no run-mode saving here
	assign clk_stop_o = all_stop_i;
	assign special_mode_o = q.special;
	assign debug_enable_o = q.enable;
	assign clksel_o = q.clksel;

	// ****************************************
	// Assertions
	// ****************************************
	property p_strap_special;
		@(posedge clk_i) disable iff (!rst_n) $rose(q.strap_done) && q.special |-> q.enable && q.active;
	endproperty
	a_strap_special: assert property (p_strap_special) else $error("Special mode not enabled and active");
	property p_strap_emul;
		@(posedge clk_i) disable iff (!rst_n)
			$rose(q.strap_done) && q.emul |-> q.enable && !q.active && (q.clksel || $past(secure_i));
	endproperty
	a_strap_emul: assert property (p_strap_emul) else $error("Emulation reset state wrong");
	property p_soft_reset;
		@(posedge clk_i) disable iff (!rst_n)
			q.strap_done && q.stop_q && !all_stop_i |=> q.st == bdu_pkg::ST_CMD && !q.ack_en && q.cmd == 8'h00;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("No soft reset on clock restart");
	property p_stop_idle;
		@(posedge clk_i) disable iff (!rst_n) q.strap_done && all_stop_i |=> q.st == bdu_pkg::ST_CMD && !bus_req_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("Command ran with all masters stopped");
	property p_bus_gate;
		@(posedge clk_i) disable iff (!rst_n)
			bus_req_o |-> bus_free_i && (!secure_eff || (q.special && q.addr < bdu_pkg::REG_SPACE_TOP));
	endproperty
	a_bus_gate: assert property (p_bus_gate) else $error("Bus request outside free or permitted space");
	property p_fw_gate;
		@(posedge clk_i) disable iff (!rst_n) fw_cmd_valid_o |-> q.enable && !$past(cpu_lowpower_i);
	endproperty
	a_fw_gate: assert property (p_fw_gate) else $error("Firmware command while disabled or low power");
	property p_active_clear;
		@(posedge clk_i) disable iff (!rst_n) $fell(q.active) |-> $past(fw_exit_i);
	endproperty
	a_active_clear: assert property (p_active_clear) else $error("Active flag cleared without table exit");
	property p_active_set;
		@(posedge clk_i) disable iff (!rst_n)
			$rose(q.active) && $past(q.strap_done) |-> $past(rx_bit_valid && q.st == bdu_pkg::ST_CMD)
			&& $past(q.enable) && !$past(cpu_lowpower_i);
	endproperty
	a_active_set: assert property (p_active_set) else $error("Active flag set without background");
	property p_clksel_write;
		@(posedge clk_i) disable iff (!rst_n)
			$changed(q.clksel) && $past(q.strap_done) |-> $past(q.st == bdu_pkg::ST_ACCESS && q.cmd == bdu_pkg::CMD_WRITE_DEBUG_REG_COMMAND);
	endproperty
	a_clksel_write: assert property (p_clksel_write) else $error("Clock select changed without register write");
	property p_sync_pulse;
		@(posedge clk_i) disable iff (!rst_n)
			rx_sync && q.strap_done && !all_stop_i && !q.stop_q && !tx_busy |-> ##18 !pin_oen_o ##128 pin_oen_o;
	endproperty
	a_sync_pulse: assert property (p_sync_pulse) else $error("Sync answer pulse wrong");
	property p_tagged_go;
		@(posedge clk_i) disable iff (!rst_n)
			in_case && q.st == bdu_pkg::ST_CMD && rx_bit_valid && q.cnt == bdu_pkg::BYTE_LAST
			&& cmd_w == bdu_pkg::CMD_TAGGED_GO |=> q.st == bdu_pkg::ST_CMD && !fw_cmd_valid_o;
	endproperty
	a_tagged_go: assert property (p_tagged_go) else $error("Tagged go was acted upon");
	property p_family;
		@(posedge clk_i) disable iff (!rst_n)
			in_case && q.st == bdu_pkg::ST_ACCESS && q.cmd == bdu_pkg::CMD_READ_DEBUG_REG_COMMAND
			&& q.addr == {bdu_pkg::DBG_PAGE, bdu_pkg::OFS_FAMILY} |=> q.data[15:8] == FAMILY_ID;
	endproperty
	a_family: assert property (p_family) else $error("Family byte read wrong");
	c_sync: cover property (@(posedge clk_i) disable iff (!rst_n) rx_sync ##1 tx_busy);
	c_fw: cover property (@(posedge clk_i) disable iff (!rst_n) fw_cmd_valid_o);
	c_bus_read: cover property (@(posedge clk_i) disable iff (!rst_n) bus_req_o && bus_ack_i && !bus_we_o);
	c_ack: cover property (@(posedge clk_i) disable iff (!rst_n) q.st == bdu_pkg::ST_ACK && q.ack_en && !tx_busy);
endmodule
`default_nettype wire

// ==== hdl/bdu_pkg.sv ====
// Shared constants and types of the single-wire background debug unit
`default_nettype none
package bdu_pkg;
	// Hardware commands, executed without the CPU, then the tagged go, which is ignored
	localparam logic [7:0] CMD_BACKGROUND = 8'h90;
	localparam logic [7:0] CMD_ACK_ENABLE = 8'hd5;
	localparam logic [7:0] CMD_ACK_DISABLE = 8'hd6;
	localparam logic [7:0] CMD_READ_DEBUG_REG_COMMAND = 8'he4;
	localparam logic [7:0] CMD_WRITE_DEBUG_REG_COMMAND = 8'hc4;
	localparam logic [7:0] CMD_READ_BYTE = 8'he0;
	localparam logic [7:0] CMD_WRITE_BYTE = 8'hc0;
	localparam logic [7:0] CMD_READ_WORD = 8'he8;
	localparam logic [7:0] CMD_WRITE_WORD = 8'hc8;
	localparam logic [7:0] CMD_TAGGED_GO = 8'h18;
	// Firmware commands occupy a contiguous opcode range
	localparam logic [7:0] FW_CMD_BASE = 8'h80;
	localparam logic [7:0] FW_CMD_COUNT = 8'h0e;
	localparam logic [23:0] FW_TABLE_BASE = 24'h7fff20;
	// Debug space: status register and family byte
	localparam logic [15:0] DBG_PAGE = 16'h7fff;
	localparam logic [7:0] OFS_STATUS = 8'h01;
	localparam logic [7:0] OFS_FAMILY = 8'h0f;
	localparam int ST_ENABLE_BIT = 7;
	localparam int ST_ACTIVE_BIT = 6;
	localparam int ST_CLKSEL_BIT = 2;
	localparam int ST_UNSEC_BIT = 1;
	localparam logic [23:0] REG_SPACE_TOP = 24'h000800;
	// Shift counts
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [4:0] WORD_LAST = 5'h0f;
	localparam logic [4:0] ADDR_LAST = 5'h17;
	// Pin timing in clock cycles
	localparam logic [7:0] SAMPLE_CYC = 8'h0a;
	localparam logic [7:0] SYNC_MIN_CYC = 8'ha0;
	localparam logic [7:0] SYNC_GAP_CYC = 8'h10;
	localparam logic [7:0] SYNC_PULSE_CYC = 8'h80;
	localparam logic [7:0] ACK_CYC = 8'h10;
	localparam logic [7:0] TX_LOW_CYC = 8'h0d;
	typedef enum logic [2:0] {
		ST_CMD    = 3'b000,
		ST_ADDR   = 3'b001,
		ST_WDATA  = 3'b010,
		ST_ACCESS = 3'b011,
		ST_FW     = 3'b100,
		ST_ACK    = 3'b101,
		ST_TX     = 3'b110
	} bdu_state_t;
endpackage
`default_nettype wire

// ==== hdl/bdu_pin_rx.sv ====
// Receive side of the debug pin: bit cells and long-low sync requests
`default_nettype none
module bdu_pin_rx #(
	parameter logic [7:0] SAMPLE   = bdu_pkg::SAMPLE_CYC,
	parameter logic [7:0] SYNC_MIN = bdu_pkg::SYNC_MIN_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	input  wire logic mute_i,
	output logic      fall_o,
	output logic      bit_valid_o,
	output logic      bit_o,
	output logic      sync_o
);
	if (SAMPLE == 8'h00 || SAMPLE >= SYNC_MIN) begin : g_chk
		$error("Sample point must lie inside the sync threshold");
	end
	typedef struct packed {
		logic       prev;
		logic       low;
		logic [7:0] cnt;
		logic       fall;
		logic       bvalid;
		logic       bval;
		logic       sync;
	} bdu_rx_t;
	bdu_rx_t q, next_q;
	always_comb begin
		next_q = q;
		next_q.prev = pin_i;
		next_q.fall = 1'b0;
		next_q.bvalid = 1'b0;
		next_q.sync = 1'b0;
		// Edges seen while this end drives the pin are its own and are ignored
		if (q.prev && !pin_i && !mute_i) begin
			next_q.low = 1'b1;
			next_q.cnt = 8'h00;
			next_q.fall = 1'b1;
		end else if (q.low) begin
			if (q.cnt != 8'hff) begin
				next_q.cnt = q.cnt + 8'h01;
			end
			if (pin_i) begin
				next_q.low = 1'b0;
				next_q.sync = (q.cnt >= SYNC_MIN);
				next_q.bvalid = (q.cnt < SAMPLE);
				next_q.bval = 1'b1;
			end else if (q.cnt == SAMPLE) begin
				next_q.bvalid = 1'b1;
				next_q.bval = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '{prev: 1'b1, default: '0};
		end else begin
			q <= next_q;
		end
	end
	assign fall_o = q.fall;
	assign bit_valid_o = q.bvalid;
	assign bit_o = q.bval;
	assign sync_o = q.sync;
endmodule
`default_nettype wire

// ==== hdl/bdu_pin_tx.sv ====
// Transmit side of the debug pin: delayed low pulses of set length
`default_nettype none
module bdu_pin_tx (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [7:0] delay_i,
	input  wire logic [7:0] len_i,
	output logic            oen_o,
	output logic            busy_o
);
	typedef struct packed {
		logic       busy;
		logic       drive;
		logic [7:0] dly;
		logic [7:0] len;
	} bdu_tx_t;
	bdu_tx_t q, next_q;
	always_comb begin
		next_q = q;
		if (!q.busy) begin
			if (start_i && len_i != 8'h00) begin
				next_q.busy = 1'b1;
				next_q.dly = delay_i;
				next_q.len = len_i - 8'h01;
			end
		end else if (q.dly != 8'h00) begin
			next_q.dly = q.dly - 8'h01;
		end else if (!q.drive) begin
			next_q.drive = 1'b1;
		end else if (q.len == 8'h00) begin
			next_q.drive = 1'b0;
			next_q.busy = 1'b0;
		end else begin
			next_q.len = q.len - 8'h01;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
	// Open drain: only ever pulls low
	assign oen_o = ~q.drive;
	assign busy_o = q.busy;
endmodule
`default_nettype wire

// ==== tb/bdu_host.sv ====
// Host model that opens bit cells on the debug wire and watches the replies
`default_nettype none
module bdu_host (
	input  wire logic clk_i,
	input  wire logic wire_i,
	output logic      low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial low_o = 1'b0;
	task automatic set(input logic l);
		low_o = l;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
		#5;
	endtask
	// ***********************
	// Bit cells, one wire only
	// ***********************
	// Gap goes first so an ack right after the last bit is not missed
	task automatic tx(input logic [23:0] d, input int c);
		for (int i = c - 1; i >= 0; i--) begin
			cyc(20);
			low_o = 1'b1;
			cyc(d[i] ? 4 : 13);
			low_o = 1'b0;
		end
	endtask
	// Held low past the device's own start so the wire never bounces high
	task automatic rx(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			cyc(20);
			low_o = 1'b1;
			cyc(5);
			low_o = 1'b0;
			cyc(5);
			d[i] = wire_i;
		end
	endtask
	task automatic ack(output int c, input int lim);
		c = 0;
		repeat (lim) begin
			@(posedge clk_i);
			if (wire_i === 1'b0)
				c++;
		end
		#5;
	endtask
	// Rate may have changed after reset or a clock restart
	task automatic sync(output int c);
		low_o = 1'b1;
		cyc(200);
		low_o = 1'b0;
		ack(c, 170);
	endtask
endmodule
`default_nettype wire

// ==== tb/bdu_core_tb.sv ====
// Self-checking bench of the background debug unit with a host model
`default_nettype none
module bdu_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] FAM = 8'h3c; // Arbitrary value
	logic        clk = 1'b0, resetn, emul, sec, erased;
	logic        stop, lowp, bfree, back, fdone, fexit;
	logic        hlow, pdrv, poen, breq, bwe, bword, fval, bgnd, lpb, cstop, spec, en, csel, wl;
	logic [15:0] wd, rd;
	logic [23:0] ba, ent, la, le;
	logic [7:0]  fcmd, lw, v;
	int          err_count = 0, total_checks = 0, nreq = 0, nfw = 0, n;
	// Pull-up wire, low when either party pulls it
	assign wl = !(hlow || (!poen && !pdrv));
	bdu_core #(.FAMILY_ID(FAM)) i_dut (.clk_i(clk), .resetn_i(resetn), .pin_i(wl), .pin_o(pdrv),
		.pin_oen_o(poen), .emul_mode_i(emul), .secure_i(sec), .nvm_erased_i(erased),
		.all_stop_i(stop), .cpu_lowpower_i(lowp), .bus_free_i(bfree), .bus_ack_i(back),
		.bus_rdata_i(rd), .bus_req_o(breq), .bus_we_o(bwe), .bus_word_o(bword),
		.bus_addr_o(ba), .bus_wdata_o(wd), .fw_cmd_valid_o(fval), .fw_cmd_o(fcmd),
		.fw_entry_addr_o(ent), .fw_done_i(fdone), .fw_exit_i(fexit), .bgnd_req_o(bgnd),
		.lowpower_block_o(lpb), .clk_stop_o(cstop), .special_mode_o(spec),
		.debug_enable_o(en), .clksel_o(csel));
	bdu_host i_host (.clk_i(clk), .wire_i(wl), .low_o(hlow));
	always #50 clk = ~clk;
	// Bus slave grants each request in the cycle it is seen and logs what it saw
	always @(posedge clk) begin
		#5;
		back = breq && !back;
		// Memory model: every location reads back as the inverse of its address
		rd = ~ba[15:0];
		if (breq) begin
			nreq++;
			la = ba;
			lw = wd[7:0];
		end
		if (fval) begin
			nfw++;
			le = ent;
		end
	end
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rst(input logic l, input logic e, input logic s);
		resetn = 1'b0;
		i_host.set(l);
		emul = e;
		sec = s;
		repeat (3) @(posedge clk);
		#5 resetn = 1'b1;
		i_host.cyc(8);
		i_host.sync(n);
		chk(24'(n), 24'h80);
	endtask
	task automatic cmd(input logic [7:0] c);
		i_host.tx(24'(c), 8);
		i_host.cyc(30);
	endtask
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		nreq = 0;
		i_host.tx(24'(bdu_pkg::CMD_WRITE_BYTE), 8);
		i_host.tx(a, 24);
		i_host.tx(24'(d), 8);
		i_host.ack(n, 40);
	endtask
	// ***********
	// Scenarios
	// ***********
	task automatic s_special();
		chk(24'(spec), 24'h1);
		chk(24'(en), 24'h1);
		chk(24'(bgnd), 24'h1);
		chk(24'(lpb), 24'h1);
	endtask
	task automatic s_family();
		cmd(bdu_pkg::CMD_ACK_ENABLE);
		i_host.tx(24'(bdu_pkg::CMD_READ_DEBUG_REG_COMMAND), 8);
		i_host.tx({bdu_pkg::DBG_PAGE, bdu_pkg::OFS_FAMILY}, 24);
		i_host.ack(n, 40);
		chk(24'(n), 24'h10);
		i_host.rx(v);
		chk(24'(v), 24'(FAM));
	endtask
	// No free cycle means no access and no ack until one appears
	task automatic s_write();
		bfree = 1'b0;
		wr(24'h000123, 8'ha5);
		chk(24'(nreq), 24'h0);
		bfree = 1'b1;
		i_host.ack(n, 40);
		chk(24'(n), 24'h10);
		chk(la, 24'h000123);
		chk(24'(lw), 24'ha5);
		chk(24'(bwe), 24'h1);
		chk(24'(bword), 24'h0);
	endtask
	task automatic s_read();
		i_host.tx(24'(bdu_pkg::CMD_READ_WORD), 8);
		i_host.tx(24'h000456, 24);
		i_host.ack(n, 40);
		chk(24'(n), 24'h10);
		chk(24'(bword), 24'h1);
		chk(24'(bwe), 24'h0);
		i_host.rx(v);
		chk(24'(v), 24'hfb);
		i_host.rx(v);
		chk(24'(v), 24'ha9);
		i_host.tx(24'(bdu_pkg::CMD_READ_BYTE), 8);
		i_host.tx(24'h000456, 24);
		i_host.ack(n, 40);
		i_host.rx(v);
		chk(24'(v), 24'ha9);
	endtask
	task automatic s_fw();
		for (int k = 0; k < 14; k++) begin
			nfw = 0;
			cmd(bdu_pkg::FW_CMD_BASE + 8'(k));
			chk(24'(nfw), 24'h1);
			chk(le, bdu_pkg::FW_TABLE_BASE + 24'(2 * k));
			chk(24'(fcmd), 24'(bdu_pkg::FW_CMD_BASE + 8'(k)));
			fdone = 1'b1;
			i_host.cyc(1);
			fdone = 1'b0;
			i_host.cyc(25);
		end
	endtask
	task automatic s_lowpower();
		fexit = 1'b1;
		i_host.cyc(1);
		fexit = 1'b0;
		i_host.cyc(2);
		chk(24'(bgnd), 24'h0);
		lowp = 1'b1;
		cmd(bdu_pkg::CMD_BACKGROUND);
		chk(24'(bgnd), 24'h0);
		wr(24'h000200, 8'h3b);
		chk(24'(n), 24'h10);
		lowp = 1'b0;
		cmd(bdu_pkg::CMD_BACKGROUND);
		chk(24'(bgnd), 24'h1);
		chk(24'(lpb), 24'h1);
		i_host.tx(24'(bdu_pkg::CMD_TAGGED_GO), 8);
		i_host.ack(n, 40);
		chk(24'(n), 24'h0);
	endtask
	task automatic s_stop();
		stop = 1'b1;
		i_host.cyc(3);
		chk(24'(cstop), 24'h1);
		stop = 1'b0;
		i_host.cyc(3);
		chk(24'(cstop), 24'h0);
		i_host.sync(n);
		chk(24'(n), 24'h80);
		wr(24'h000345, 8'h5d);
		chk(24'(n), 24'h0);
		chk(la, 24'h000345);
	endtask
	task automatic s_secure();
		rst(1'b1, 1'b0, 1'b1);
		wr(24'h000010, 8'h11);
		chk(24'(nreq != 0), 24'h1);
		wr(24'h004000, 8'h11);
		chk(24'(nreq), 24'h0);
		nfw = 0;
		cmd(bdu_pkg::FW_CMD_BASE);
		chk(24'(nfw), 24'h0);
		// A passed erase check lifts the restriction
		erased = 1'b1;
		wr(24'h004000, 8'h11);
		chk(24'(nreq != 0), 24'h1);
	endtask
	task automatic s_modes();
		rst(1'b0, 1'b1, 1'b0);
		chk(24'(en), 24'h1);
		chk(24'(bgnd), 24'h0);
		chk(24'(csel), 24'h1);
		chk(24'(spec), 24'h0);
		rst(1'b0, 1'b0, 1'b0);
		chk(24'(en), 24'h0);
		cmd(bdu_pkg::FW_CMD_BASE);
		chk(24'(nfw), 24'h0);
	endtask
	initial begin
		{emul, sec, erased, stop, lowp, fdone, fexit} = 7'h00;
		bfree = 1'b1;
		rst(1'b1, 1'b0, 1'b0);
		s_special();
		s_family();
		s_write();
		s_read();
		s_fw();
		s_lowpower();
		s_stop();
		s_secure();
		s_modes();
		print_verdict();
	end
	// Hang guard well beyond the longest expected run
	initial begin
		#4000000;
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
